// ### bench/sync_ref_monitor_monitor.sv
// port assertions for the sync reference monitor
`timescale 1ns/1ps
module sync_ref_monitor_monitor #(
   parameter int DIV_W = 16
) (
   input wire logic             core_clk_i,
   input wire logic             rst_n_i,
   input wire logic             sen_i,
   input wire logic             sdio_oe_o,
   input wire logic             shared_io_pin_0_i,
   input wire logic [5:0]       sync_taps_i,
   input wire logic             term_200_o,
   input wire logic             sync_pin_selected_o,
   input wire logic [DIV_W-1:0] div_count_o,
   input wire logic [7:0]       sync_window_status_o
);
   logic       pin_q;
   logic [4:0] exp_q;
   wire logic       hit_w  = sync_pin_selected_o & shared_io_pin_0_i & ~pin_q;
   wire logic [4:0] diff_w = sync_taps_i[4:0] ^ sync_taps_i[5:1];
   wire logic [4:0] low_w  = diff_w & (~diff_w + 5'h01);

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pin_q <= 1'b0;
         exp_q <= 5'h00;
      end else begin
         pin_q <= shared_io_pin_0_i & sync_pin_selected_o;
         exp_q <= hit_w ? low_w : exp_q;
      end
   end

   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_sync_hit;
      hit_w;
   endsequence
   sequence s_status_flags;
      ##[1:2] sync_window_status_o[4:0] == exp_q;
   endsequence

   property p_top_zero;
      sync_window_status_o[7] == 1'b0;
   endproperty
   property p_any;
      sync_window_status_o[5] == (|sync_window_status_o[4:0]);
   endproperty
   property p_one_flag;
      $onehot0(sync_window_status_o[4:0]);
   endproperty
   property p_edge_seen;
      s_sync_hit |-> ##[1:2] sync_window_status_o[6];
   endproperty
   property p_flags;
      s_sync_hit |-> s_status_flags;
   endproperty
   property p_quiet;
      $changed(sync_window_status_o[5:0]) |->
         $past(hit_w) || $past(hit_w, 2) || $past(sen_i) == 1'b0;
   endproperty
   property p_div_step;
      div_count_o == DIV_W'($past(div_count_o) + 1'b1) || div_count_o == '0;
   endproperty
   property p_term_write;
      $changed(term_200_o) |-> $past(sen_i) == 1'b0;
   endproperty
   property p_oe_frame;
      sdio_oe_o |-> !sen_i;
   endproperty

   a_top_zero:   assert property (p_top_zero)   else $error("status bit 7 set");
   a_any:        assert property (p_any)        else $error("summary flag wrong");
   a_one_flag:   assert property (p_one_flag)   else $error("several window flags");
   a_edge_seen:  assert property (p_edge_seen)  else $error("edge seen not set");
   a_flags:      assert property (p_flags)      else $error("window flag wrong");
   a_quiet:      assert property (p_quiet)      else $error("status moved alone");
   a_div_step:   assert property (p_div_step)   else $error("divider skipped");
   a_term_write: assert property (p_term_write) else $error("termination moved alone");
   a_oe_frame:   assert property (p_oe_frame)   else $error("data driven outside frame");
   c_sync_hit:   cover property (s_sync_hit);
endmodule : sync_ref_monitor_monitor

bind sync_ref_monitor sync_ref_monitor_monitor #(.DIV_W(DIV_W)) i_sync_ref_monitor_monitor (
   .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .sen_i(sen_i), .sdio_oe_o(sdio_oe_o),
   .shared_io_pin_0_i(shared_io_pin_0_i), .sync_taps_i(sync_taps_i), .term_200_o(term_200_o),
   .sync_pin_selected_o(sync_pin_selected_o), .div_count_o(div_count_o),
   .sync_window_status_o(sync_window_status_o));

// ### bench/sync_ref_monitor_tb.sv
// self-checking bench for the sync reference monitor
`timescale 1ns/1ps
module sync_ref_monitor_tb;
   logic        core_clk_i;
   logic        rst_n_i;
   logic        sclk_i;
   logic        sen_i;
   logic        sdio_i;
   logic        sdio_o;
   logic        sdio_oe_o;
   logic        pin_w;
   logic [5:0]  taps_w;
   logic        term_200_o;
   logic [7:0]  freq_range_o;
   logic [7:0]  nyquist_zone_o;
   logic        decim_enable_o;
   logic        sync_pin_selected_o;
   logic [13:0] ramp_o;
   logic [15:0] div_count_o;
   logic [47:0] osc_phase_o;
   logic [7:0]  sync_window_status_o;
   logic [7:0]  rd;
   int          num_errors;
   int          n_compared;

   sync_ref_monitor i_sync_ref_monitor (
      .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk_i), .sen_i(sen_i),
      .sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe_o(sdio_oe_o), .shared_io_pin_0_i(pin_w),
      .sync_taps_i(taps_w), .term_200_o(term_200_o), .freq_range_o(freq_range_o),
      .nyquist_zone_o(nyquist_zone_o), .decim_enable_o(decim_enable_o),
      .sync_pin_selected_o(sync_pin_selected_o), .ramp_o(ramp_o), .div_count_o(div_count_o),
      .osc_phase_o(osc_phase_o), .sync_window_status_o(sync_window_status_o));
   sync_source i_sync_source (.core_clk_i(core_clk_i), .pin_o(pin_w), .taps_o(taps_w));

   initial begin
      core_clk_i = 1'b0;
      forever #12.5 core_clk_i = ~core_clk_i;
   end

   task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %0h seen %0h", name, exp, seen);
      end
   endtask : check

   // one serial frame, sclk high held two clocks and low three between bits
   task automatic xfer(input logic rd_n, input logic [11:0] a, input logic [7:0] wd,
                       output logic [7:0] rv);
      logic [23:0] f;
      f = {rd_n, 3'h0, a, wd};
      rv = 8'h00;
      sen_i = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         sdio_i = f[i];
         @(negedge core_clk_i);
         sclk_i = 1'b1;
         repeat (2) @(negedge core_clk_i);
         sclk_i = 1'b0;
         repeat (2) @(negedge core_clk_i);
         if (i >= 1 && i <= 8) rv[i-1] = sdio_o;
         if (rd_n && i == 4) check("sdio drive", sdio_oe_o, 1'b1);
      end
      sen_i = 1'b1;
      repeat (2) @(negedge core_clk_i);
   endtask : xfer

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      xfer(1'b0, a, d, rd);
   endtask : wr

   task automatic rd_chk(input string name, input logic [11:0] a, input logic [7:0] exp);
      xfer(1'b1, a, 8'h00, rd);
      check(name, rd, exp);
   endtask : rd_chk

   task automatic t_defaults;
      rd_chk("nyquist reg", sync_monitor_pkg::ADDR_NYQ_ZONE, 8'h00);
      rd_chk("range reg", sync_monitor_pkg::ADDR_FREQ_RANGE, 8'h00);
      rd_chk("term reg", sync_monitor_pkg::ADDR_TERM, 8'h00);
      rd_chk("pin cfg", sync_monitor_pkg::ADDR_PIN_CFG, 8'hFF);
      rd_chk("mask reg", sync_monitor_pkg::ADDR_SYNC_MASK, 8'h07);
      wr(12'h7FF, 8'hAA);
      rd_chk("unmapped", 12'h7FF, 8'h00);
      check("term pin", term_200_o, 1'b0);
      check("nyquist pin", nyquist_zone_o, 8'h00);
      i_sync_source.pulse(6'h03, 2);
      repeat (2) @(negedge core_clk_i);
      check("status unselected", sync_window_status_o, 8'h00);
   endtask : t_defaults

   task automatic t_config;
      wr(sync_monitor_pkg::ADDR_TERM, 8'h01);
      check("term pin", term_200_o, 1'b1);
      wr(sync_monitor_pkg::ADDR_FREQ_RANGE, 8'h5A);
      wr(sync_monitor_pkg::ADDR_NYQ_ZONE, 8'h02);
      check("range pin", freq_range_o, 8'h5A);
      check("nyquist pin", nyquist_zone_o, 8'h02);
      wr(sync_monitor_pkg::ADDR_PIN_CFG, 8'h00);
      check("pin selected", sync_pin_selected_o, 1'b1);
   endtask : t_config

   task automatic t_windows;
      for (int i = 0; i < 5; i++) begin
         i_sync_source.pulse(6'((1 << (i + 1)) - 1), 2);
         repeat (2) @(negedge core_clk_i);
         check("status pins", sync_window_status_o, {3'b011, 5'(1 << i)});
         rd_chk("status reg", sync_monitor_pkg::ADDR_WIN_STATUS, {3'b011, 5'(1 << i)});
      end
      i_sync_source.pulse(6'h00, 2);
      repeat (2) @(negedge core_clk_i);
      check("status quiet edge", sync_window_status_o, 8'h40);
   endtask : t_windows

   task automatic t_sticky;
      wr(sync_monitor_pkg::ADDR_WIN_STATUS, 8'h40);
      rd_chk("status cleared", sync_monitor_pkg::ADDR_WIN_STATUS, 8'h00);
      i_sync_source.pulse(6'h07, 2);
      repeat (2) @(negedge core_clk_i);
      check("status again", sync_window_status_o, 8'h64);
   endtask : t_sticky

   // which of divider, phase, ramp a single sync pulse returns to zero
   task automatic sync_case(input logic [7:0] dec, input logic [7:0] mask,
                            input logic [2:0] exp);
      logic [2:0] z;
      z = 3'b000;
      wr(sync_monitor_pkg::ADDR_DECIM, dec);
      wr(sync_monitor_pkg::ADDR_SYNC_MASK, mask);
      check("decim pin", decim_enable_o, dec != 8'h00);
      repeat (4) @(negedge core_clk_i);
      i_sync_source.pulse(6'h00, 1);
      for (int i = 0; i < 3; i++) begin
         z |= {ramp_o === '0, osc_phase_o === '0, div_count_o === '0};
         @(negedge core_clk_i);
      end
      check("cleared blocks", z, exp);
   endtask : sync_case

   task automatic t_decim;
      sync_case(8'h01, 8'h07, 3'b011);
      sync_case(8'h01, 8'h02, 3'b010);
   endtask : t_decim

   task automatic t_bypass;
      sync_case(8'h00, 8'h04, 3'b100);
      sync_case(8'h00, 8'h00, 3'b000);
   endtask : t_bypass

   task automatic end_sim;
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : end_sim

   initial begin
      rst_n_i = 1'b0;
      sclk_i = 1'b0;
      sen_i = 1'b1;
      sdio_i = 1'b0;
      num_errors = 0;
      n_compared = 0;
      repeat (5) @(negedge core_clk_i);
      rst_n_i = 1'b1;
      @(negedge core_clk_i);
      t_defaults;
      t_config;
      t_windows;
      t_sticky;
      t_decim;
      t_bypass;
      end_sim;
   end
endmodule : sync_ref_monitor_tb

// ### bench/sync_source.sv
// far-side model: sync reference source driving the shared pin and detector taps
`timescale 1ns/1ps
module sync_source (
   input  wire logic                                core_clk_i,
   output logic                                     pin_o,
   output logic [sync_monitor_pkg::NUM_TAPS-1:0]    taps_o
);
   initial begin
      pin_o  = 1'b0;
      taps_o = 6'h2A;
   end

   // one single pulse, rising on the sampling clock falling edge
   task automatic pulse(input logic [5:0] taps, input int width);
      @(negedge core_clk_i);
      taps_o = taps;
      pin_o  = 1'b1;
      repeat (width) @(negedge core_clk_i);
      pin_o  = 1'b0;
      taps_o = ~taps;
   endtask : pulse
endmodule : sync_source

// ### rtl/sync_counter.sv
// free running counter that a sync event returns to zero
`timescale 1ns/1ps
module sync_counter #(
   parameter int          WIDTH = 14,
   parameter logic [31:0] STEP  = 32'h0000_0001
) (
   input  wire logic             core_clk_i,
   input  wire logic             rst_n_i,
   input  wire logic             sync_clear_i,
   output logic [WIDTH-1:0]      value_o
);
   logic [WIDTH-1:0] value_q;
   logic [WIDTH-1:0] value_d;

   assign value_d = sync_clear_i ? '0 : value_q + WIDTH'(STEP);
   assign value_o = value_q;

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         value_q <= '0;
      end else begin
         value_q <= value_d;
      end
   end
endmodule : sync_counter

// ### rtl/sync_ctl_if.sv
// link between the sync core and the window classifier
`timescale 1ns/1ps
interface sync_ctl_if;
   logic                                   sync_event;
   logic [sync_monitor_pkg::NUM_TAPS-1:0]    taps;
   logic [sync_monitor_pkg::NUM_WINDOWS-1:0] flags;
   logic                                   any;

   modport core (
      output sync_event,
      output taps,
      input  flags,
      input  any
   );

   modport classifier (
      input  sync_event,
      input  taps,
      output flags,
      output any
   );
endinterface : sync_ctl_if

// ### rtl/sync_monitor_pkg.sv
// constants for the sync reference handling and window monitor
//
// Overview of operation
// RULE1 - frequency range and nyquist zone registers steer correction; zone one after reset.
// RULE2 - termination is 100 ohm by default; a register write selects 200 ohm.
// RULE3 - bypass mode keeps latency untouched; a sync event restarts the ramp pattern.
// RULE4 - decimation mode: sync event returns dividers and oscillator phase to known state.
// RULE5 - writing 0x00 to pin configuration 0x146 makes shared_io_pin_0 the sync input.
// RULE6 - one single sync pulse from the source is enough to synchronise.
// RULE7 - software masks choose which internal blocks a sync event resets.
// RULE8 - source places sync rising edge on the sampling clock falling edge.
// RULE9 - sync is captured at the sampling clock rising edge, 60ps after it.
// RULE10 - monitor detects a transition from 60ps before to 140ps after the edge.
// RULE11 - monitor raises exactly one of five window flags; the code raises none when no tap transition is seen.
// RULE12 - monitor status updates on every rising edge of sync reference.
// RULE13 - edge seen bit 6 is sticky; software clears it explicitly.
// RULE14 - status 0x140: bit7 zero, bit6 edge seen, bit5 summary, bits4-0 flags.
// RULE15 - summary bit 5 set when any window flag is set at last update.
package sync_monitor_pkg;

   // ***************************************************************
   // serial frame layout
   // ***************************************************************
   localparam int          FRAME_BITS    = 24;
   localparam int          HEADER_BITS   = 16;
   localparam int          ADDR_W        = 12;
   localparam int          DATA_W        = 8;
   localparam logic [4:0]  CNT_HEADER    = 5'h10;
   localparam logic [4:0]  CNT_LAST      = 5'h17;

   // ***************************************************************
   // register offsets
   // ***************************************************************
   localparam logic [11:0] ADDR_TERM        = 12'h11A;
   localparam logic [11:0] ADDR_FREQ_RANGE  = 12'h132;
   localparam logic [11:0] ADDR_WIN_STATUS  = 12'h140;
   localparam logic [11:0] ADDR_PIN_CFG     = 12'h146;
   localparam logic [11:0] ADDR_SYNC_MASK   = 12'h14A;
   localparam logic [11:0] ADDR_DECIM       = 12'h169;
   localparam logic [11:0] ADDR_NYQ_ZONE    = 12'h16B;

   // ***************************************************************
   // fields and reset values
   // ***************************************************************
   localparam int          STAT_EDGE_BIT    = 6;
   localparam int          STAT_ANY_BIT     = 5;
   localparam int          MASK_DIV_BIT     = 0;
   localparam int          MASK_PHASE_BIT   = 1;
   localparam int          MASK_RAMP_BIT    = 2;
   localparam int          TERM_200_BIT     = 0;
   localparam logic [7:0]  PIN_CFG_SYNC     = 8'h00;
   localparam logic [7:0]  PIN_CFG_RESET    = 8'hFF;
   localparam logic [7:0]  SYNC_MASK_RESET  = 8'h07;
   localparam logic [7:0]  NYQ_ZONE_FIRST   = 8'h00;
   localparam logic [7:0]  FREQ_RANGE_RESET = 8'h00;
   localparam logic [7:0]  TERM_RESET       = 8'h00;
   localparam logic [7:0]  DECIM_RESET      = 8'h00;
   localparam logic [7:0]  READ_UNMAPPED    = 8'h00;

   // ***************************************************************
   // detector timing, in ps, relative to the sampling rising edge
   // ***************************************************************
   localparam int          CAPTURE_DELAY_PS = 60;
   localparam int          WIN_START_PS     = -60;
   localparam int          WIN_END_PS       = 140;
   localparam int          WIN_STEP_PS      = 40;
   localparam int          NUM_WINDOWS      = (WIN_END_PS - WIN_START_PS) / WIN_STEP_PS;
   localparam int          NUM_TAPS         = NUM_WINDOWS + 1;

endpackage : sync_monitor_pkg

// ### rtl/sync_ref_monitor.sv
// sync reference capture, sync masks, window monitor and serial registers
`timescale 1ns/1ps
module sync_ref_monitor #(
   parameter int          RAMP_W      = 14,
   parameter int          DIV_W       = 16,
   parameter int          PHASE_W     = 48,
   parameter logic [31:0] PHASE_STEP  = 32'h0000_0001
) (
   input  wire logic                                   core_clk_i,
   input  wire logic                                   rst_n_i,
   // serial register port
   input  wire logic                                   sclk_i,
   input  wire logic                                   sen_i,
   input  wire logic                                   sdio_i,
   output logic                                        sdio_o,
   output logic                                        sdio_oe_o,
   // shared pin and edge detector taps
   input  wire logic                                   shared_io_pin_0_i,
   input  wire logic [sync_monitor_pkg::NUM_TAPS-1:0]  sync_taps_i,
   // configuration seen by the analog side
   output logic                                        term_200_o,
   output logic [7:0]                                  freq_range_o,
   output logic [7:0]                                  nyquist_zone_o,
   output logic                                        decim_enable_o,
   output logic                                        sync_pin_selected_o,
   // internal state reset by sync events, window status updated by them
   output logic [RAMP_W-1:0]                           ramp_o,
   output logic [DIV_W-1:0]                            div_count_o,
   output logic [PHASE_W-1:0]                          osc_phase_o,
   output logic [7:0]                                  sync_window_status_o
);

   // ***************************************************************
   // serial port sampling
   // ***************************************************************
   logic        sclk_q;
   logic        sclk_rise;
   logic        sclk_fall;
   logic        frame_active;

   assign frame_active = ~sen_i;
   assign sclk_rise    = frame_active & sclk_i & ~sclk_q;
   assign sclk_fall    = frame_active & ~sclk_i & sclk_q;

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sclk_q <= 1'b0;
      end else begin
         sclk_q <= sclk_i;
      end
   end

   // ***************************************************************
   // serial frame shifter
   // ***************************************************************
   logic [4:0]                            bit_cnt_q;
   logic [4:0]                            bit_cnt_d;
   logic [sync_monitor_pkg::FRAME_BITS-2:0] shift_q;
   logic [sync_monitor_pkg::FRAME_BITS-2:0] shift_d;
   logic                                  is_read_q;
   logic                                  header_done;
   logic                                  frame_done;
   logic [sync_monitor_pkg::ADDR_W-1:0]   hdr_addr;
   logic [sync_monitor_pkg::ADDR_W-1:0]   addr_q;
   logic [sync_monitor_pkg::DATA_W-1:0]   wr_data;
   logic                                  wr_en;

   assign header_done = sclk_rise & (bit_cnt_q == sync_monitor_pkg::CNT_HEADER - 5'h01);
   assign frame_done  = sclk_rise & (bit_cnt_q == sync_monitor_pkg::CNT_LAST);
   assign hdr_addr    = {shift_q[10:0], sdio_i};
   assign wr_data     = {shift_q[6:0], sdio_i};
   assign wr_en       = frame_done & ~is_read_q;
   assign shift_d     = sclk_rise ? {shift_q[21:0], sdio_i} : shift_q;
   assign bit_cnt_d   = !frame_active ? 5'h00 :
                        (sclk_rise && bit_cnt_q != sync_monitor_pkg::CNT_LAST + 5'h01) ?
                        bit_cnt_q + 5'h01 : bit_cnt_q;

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bit_cnt_q <= 5'h00;
         shift_q   <= '0;
      end else begin
         bit_cnt_q <= bit_cnt_d;
         shift_q   <= shift_d;
      end
   end

   // first bit of a frame selects read
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         is_read_q <= 1'b0;
      end else if (sclk_rise && bit_cnt_q == 5'h00) begin
         is_read_q <= sdio_i;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         addr_q <= '0;
      end else if (header_done) begin
         addr_q <= hdr_addr;
      end
   end

   // ***************************************************************
   // write decode
   // ***************************************************************
   logic we_term;
   logic we_freq;
   logic we_stat;
   logic we_pin;
   logic we_mask;
   logic we_decim;
   logic we_nyq;

   assign we_term  = wr_en & (addr_q == sync_monitor_pkg::ADDR_TERM);
   assign we_freq  = wr_en & (addr_q == sync_monitor_pkg::ADDR_FREQ_RANGE);
   assign we_stat  = wr_en & (addr_q == sync_monitor_pkg::ADDR_WIN_STATUS);
   assign we_pin   = wr_en & (addr_q == sync_monitor_pkg::ADDR_PIN_CFG);
   assign we_mask  = wr_en & (addr_q == sync_monitor_pkg::ADDR_SYNC_MASK);
   assign we_decim = wr_en & (addr_q == sync_monitor_pkg::ADDR_DECIM);
   assign we_nyq   = wr_en & (addr_q == sync_monitor_pkg::ADDR_NYQ_ZONE);

   // ***************************************************************
   // configuration registers
   // ***************************************************************
   logic [7:0] term_q;
   logic [7:0] freq_q;
   logic [7:0] pin_cfg_q;
   logic [7:0] mask_q;
   logic [7:0] decim_q;
   logic [7:0] nyq_q;

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         term_q <= sync_monitor_pkg::TERM_RESET;                         // see RULE2
         freq_q <= sync_monitor_pkg::FREQ_RANGE_RESET;
         nyq_q  <= sync_monitor_pkg::NYQ_ZONE_FIRST;                     // see RULE1
      end else begin
         if (we_term) term_q <= wr_data;                                 // see RULE2
         if (we_freq) freq_q <= wr_data;                                 // see RULE1
         if (we_nyq)  nyq_q  <= wr_data;                                 // see RULE1
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pin_cfg_q <= sync_monitor_pkg::PIN_CFG_RESET;
         mask_q    <= sync_monitor_pkg::SYNC_MASK_RESET;
         decim_q   <= sync_monitor_pkg::DECIM_RESET;
      end else begin
         if (we_pin)   pin_cfg_q <= wr_data;                             // see RULE5
         if (we_mask)  mask_q    <= wr_data;                             // see RULE7
         if (we_decim) decim_q   <= {4'h0, wr_data[3:0]};
      end
   end

   assign term_200_o     = term_q[sync_monitor_pkg::TERM_200_BIT];       // see RULE2
   assign freq_range_o   = freq_q;
   assign nyquist_zone_o = nyq_q;
   assign decim_enable_o = decim_q[3:0] != 4'h0;

   // ***************************************************************
   // sync reference capture
   // ***************************************************************
   logic pin_is_sync;
   logic sync_level;
   logic sync_prev_q;
   logic sync_event;

   assign pin_is_sync         = pin_cfg_q == sync_monitor_pkg::PIN_CFG_SYNC; // see RULE5
   assign sync_pin_selected_o = pin_is_sync;
   // pin is already sampled on the rising sampling edge
   assign sync_level          = shared_io_pin_0_i & pin_is_sync;        // see RULE9
   // one rising edge is a full event, no pulse train needed
   assign sync_event          = sync_level & ~sync_prev_q;              // see RULE6

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync_prev_q <= 1'b0;
      end else begin
         sync_prev_q <= sync_level;
      end
   end

   // ***************************************************************
   // sync masks steer which state is reset
   // ***************************************************************
   logic clr_div;
   logic clr_phase;
   logic clr_ramp;

   assign clr_div   = sync_event & decim_enable_o
                      & mask_q[sync_monitor_pkg::MASK_DIV_BIT];          // see RULE4
   assign clr_phase = sync_event & decim_enable_o
                      & mask_q[sync_monitor_pkg::MASK_PHASE_BIT];        // see RULE7
   // bypass latency is fixed, only the ramp restarts
   assign clr_ramp  = sync_event & ~decim_enable_o
                      & mask_q[sync_monitor_pkg::MASK_RAMP_BIT];         // see RULE3

   sync_counter #(
      .WIDTH (DIV_W),
      .STEP  (32'h0000_0001)
   ) u_divider (
      .core_clk_i   (core_clk_i),
      .rst_n_i      (rst_n_i),
      .sync_clear_i (clr_div),
      .value_o      (div_count_o)
   );

   sync_counter #(
      .WIDTH (PHASE_W),
      .STEP  (PHASE_STEP)
   ) u_osc_phase (
      .core_clk_i   (core_clk_i),
      .rst_n_i      (rst_n_i),
      .sync_clear_i (clr_phase),
      .value_o      (osc_phase_o)
   );

   sync_counter #(
      .WIDTH (RAMP_W),
      .STEP  (32'h0000_0001)
   ) u_ramp (
      .core_clk_i   (core_clk_i),
      .rst_n_i      (rst_n_i),
      .sync_clear_i (clr_ramp),
      .value_o      (ramp_o)
   );

   // ***************************************************************
   // window monitor
   // ***************************************************************
   sync_ctl_if ctl ();

   assign ctl.sync_event = sync_event;                                   // see RULE12
   assign ctl.taps       = sync_taps_i;                                  // see RULE10

   sync_window_classifier u_classifier (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .ctl        (ctl)
   );

   logic edge_seen_q;
   logic edge_clr;

   assign edge_clr = we_stat & wr_data[sync_monitor_pkg::STAT_EDGE_BIT];

   // set wins over a clear in the same cycle
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         edge_seen_q <= 1'b0;
      end else if (sync_event) begin
         edge_seen_q <= 1'b1;                                            // see RULE13
      end else if (edge_clr) begin
         edge_seen_q <= 1'b0;                                            // see RULE13
      end
   end

   logic [7:0] status_word;

   assign status_word = {1'b0, edge_seen_q, ctl.any, ctl.flags};         // see RULE14
   assign sync_window_status_o = status_word;

   // ***************************************************************
   // read path
   // ***************************************************************
   logic [7:0] rd_mux;
   logic [7:0] rd_sh_q;
   logic       sdio_q;
   logic       rd_phase;

   assign rd_mux = (hdr_addr == sync_monitor_pkg::ADDR_TERM)       ? term_q    :
                   (hdr_addr == sync_monitor_pkg::ADDR_FREQ_RANGE) ? freq_q    :
                   (hdr_addr == sync_monitor_pkg::ADDR_WIN_STATUS) ? status_word :
                   (hdr_addr == sync_monitor_pkg::ADDR_PIN_CFG)    ? pin_cfg_q :
                   (hdr_addr == sync_monitor_pkg::ADDR_SYNC_MASK)  ? mask_q    :
                   (hdr_addr == sync_monitor_pkg::ADDR_DECIM)      ? decim_q   :
                   (hdr_addr == sync_monitor_pkg::ADDR_NYQ_ZONE)   ? nyq_q     :
                   sync_monitor_pkg::READ_UNMAPPED;

   assign rd_phase = frame_active & is_read_q
                     & (bit_cnt_q >= sync_monitor_pkg::CNT_HEADER)
                     & (bit_cnt_q <= sync_monitor_pkg::CNT_LAST);

   // data bits leave on falling serial clock, msb first
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rd_sh_q <= 8'h00;
         sdio_q  <= 1'b0;
      end else if (header_done) begin
         rd_sh_q <= rd_mux;
      end else if (sclk_fall && rd_phase) begin
         sdio_q  <= rd_sh_q[7];
         rd_sh_q <= {rd_sh_q[6:0], 1'b0};
      end
   end

   assign sdio_o    = sdio_q;
   assign sdio_oe_o = rd_phase;

endmodule : sync_ref_monitor

// ### rtl/sync_window_classifier.sv
// turns detector taps into at most one window flag per sync edge
`timescale 1ns/1ps
module sync_window_classifier (
   input  wire logic          core_clk_i,
   input  wire logic          rst_n_i,
   sync_ctl_if.classifier     ctl
);
   localparam int NW = sync_monitor_pkg::NUM_WINDOWS;

   logic [NW-1:0] trans;
   logic [NW-1:0] onehot;
   logic [NW-1:0] flags_q;
   logic          any_q;

   // a transition between neighbouring taps marks the window
   assign trans  = ctl.taps[NW-1:0] ^ ctl.taps[NW:1];                    // see RULE10
   // lowest window wins so only one flag rises
   assign onehot = trans & (~trans + {{(NW-1){1'b0}}, 1'b1});            // see RULE11

   assign ctl.flags = flags_q;
   assign ctl.any   = any_q;

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         flags_q <= '0;
         any_q   <= 1'b0;
      end else if (ctl.sync_event) begin                                 // see RULE12
         flags_q <= onehot;
         any_q   <= |onehot;                                             // see RULE15
      end
   end
endmodule : sync_window_classifier
